/* core/seg_lcd_enable_ram.sv */
// Purpose: Frontplane enable bank, segment RAM and mode selects
// Assumes: Avalon-MM slave with waitrequest on i_clk (25 MHz)
// Notes:   Segment RAM has no reset; contents unknown until written
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps

module seg_lcd_enable_ram
  import seg_lcd_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire logic [ADDR_W-1:0]     i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [DATA_W-1:0]     i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [DATA_W-1:0]     o_avs_readdata,
  output logic                       o_avs_waitrequest,
  output logic                       o_waveform_run,
  output logic [1:0]                 o_duty_select,
  output logic                       o_bias_select,
  output logic [NUM_FP-1:0]          o_fp_oe,
  output logic [NUM_BP-1:0]          o_bp_oe,
  output logic [NUM_FP*NUM_BP-1:0]   o_segment_on_bit
);

  function automatic logic [3:0] bp_mask(input logic [1:0] duty);
    logic [3:0] m;
    m = BP_MASK_QUARTER;
    case (duty)
      DUTY_STATIC: m = BP_MASK_STATIC;
      DUTY_HALF:   m = BP_MASK_HALF;
      DUTY_THIRD:  m = BP_MASK_THIRD;
      default:     m = BP_MASK_QUARTER;
    endcase
    return m;
  endfunction : bp_mask

  // Refuse package sizes the decoding cannot serve
  if (NUM_FP != FPEN_REGS * 8)
  begin : g_chk_fpen
    $error("enable registers must cover every frontplane");
  end
  if (NUM_FP * NUM_BP != RAM_BYTES * 8 || RAM_BYTES != 16)
  begin : g_chk_ram
    $error("segment storage must hold one bit per segment");
  end
  if (NUM_BP != 4 || FPEN_REGS != 4)
  begin : g_chk_sel
    $error("select and mask widths are fixed at four");
  end
  if (IDX_W != ADDR_W - 2 || DATA_W < 8)
  begin : g_chk_bus
    $error("bus widths do not fit the register map");
  end

  logic                   driver_master_enable;
  logic [NUM_FP-1:0]      frontplane_output_enable;
  logic [7:0]             segment_storage [RAM_BYTES];

  wire  logic [IDX_W-1:0] idx        = i_avs_address[ADDR_W-1:2];
  wire  logic             aligned    = (i_avs_address[1:0] == 2'h0);
  wire  logic             is_ctrl    = aligned && (idx == IDX_CTRL);
  wire  logic             is_fpen    = aligned && (idx >= IDX_FPEN_BASE)
                                       && (idx <= IDX_FPEN_LAST);
  wire  logic             is_ram     = aligned && (idx >= IDX_RAM_BASE)
                                       && (idx <= IDX_RAM_LAST);
  wire  logic [1:0]       fpen_sel   = 2'(idx - IDX_FPEN_BASE);
  wire  logic [3:0]       ram_sel    = 4'(idx - IDX_RAM_BASE);
  wire  logic             bus_req    = i_avs_read || i_avs_write;
  wire  logic             wr_fire    = i_avs_write && !o_avs_waitrequest
                                       && i_avs_byteenable[0];
  wire  logic [7:0]       wr_byte    = i_avs_writedata[7:0];

  wire  logic             ctrl_wr    = wr_fire && is_ctrl;
  wire  logic             fpen_wr    = wr_fire && is_fpen;
  wire  logic             ram_wr     = wr_fire && is_ram;

  // Values after this edge, so outputs follow a write at once
  wire  logic             next_en    = ctrl_wr ? wr_byte[CTRL_EN_BIT]
                                       : driver_master_enable;
  wire  logic [1:0]       next_duty  = ctrl_wr
                                       ? wr_byte[CTRL_DUTY_LSB +: 2]
                                       : o_duty_select;
  wire  logic             next_bias  = ctrl_wr ? wr_byte[CTRL_BIAS_BIT]
                                       : o_bias_select;
  logic [NUM_FP-1:0]      next_fpen;

  always_comb
  begin
    next_fpen = frontplane_output_enable;
    if (fpen_wr)
    begin
      next_fpen[{fpen_sel, 3'h0} +: 8] = wr_byte;
    end
  end

  wire  logic [NUM_FP-1:0] next_fp_oe = next_en ? next_fpen
                                        : '0;
  wire  logic [3:0]        next_bp_oe = next_en ? bp_mask(next_duty)
                                        : 4'h0;

  wire  logic [7:0] ctrl_rd = {driver_master_enable, 4'h0, o_bias_select,
                               o_duty_select};
  wire  logic [7:0] rd_byte =
    is_ctrl ? ctrl_rd
    : is_fpen ? frontplane_output_enable[{fpen_sel, 3'h0} +: 8]
    : is_ram ? segment_storage[ram_sel]
    : 8'h00;

  // Bus answer: waitrequest drops for one cycle after a request
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end
    else
    begin
      o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest)
      begin
        o_avs_readdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Control and enable state
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      driver_master_enable     <= EN_RESET;
      o_waveform_run           <= EN_RESET;
      o_duty_select            <= DUTY_RESET;
      o_bias_select            <= BIAS_RESET;
      frontplane_output_enable <= FPEN_RESET;
      o_fp_oe                  <= FPEN_RESET;
      o_bp_oe                  <= 4'h0;
    end
    else
    begin
      driver_master_enable     <= next_en;
      o_waveform_run           <= next_en;
      o_duty_select            <= next_duty;
      o_bias_select            <= next_bias;
      frontplane_output_enable <= next_fpen;
      o_fp_oe                  <= next_fp_oe;
      o_bp_oe                  <= next_bp_oe;
    end
  end

  // Segment storage: no reset, separate from control writes
  always_ff @(posedge i_clk)
  begin
    if (ram_wr)
    begin
      segment_storage[ram_sel] <= wr_byte;
    end
  end

  // Byte k: low nibble frontplane 2k, high nibble frontplane 2k+1
  genvar g;
  generate
    for (g = 0; g < RAM_BYTES; g++)
    begin : g_seg
      assign o_segment_on_bit[g*8 +: 8] = segment_storage[g];
    end
  endgenerate

  // Assertions
  sequence s_fpen_write;
    fpen_wr;
  endsequence

  sequence s_ram_write;
    ram_wr;
  endsequence

  sequence s_ram_read;
    i_avs_read && o_avs_waitrequest && is_ram;
  endsequence

  property p_fp_gate;
    @(posedge i_clk) disable iff (!i_rst_b)
      o_waveform_run |-> (o_fp_oe == frontplane_output_enable);
  endproperty
  a_fp_gate: assert property (p_fp_gate)
    else $error("frontplane outputs differ from enables while running");

  property p_master_off;
    @(posedge i_clk) disable iff (!i_rst_b)
      !o_waveform_run |-> (o_fp_oe == '0) && (o_bp_oe == 4'h0);
  endproperty
  a_master_off: assert property (p_master_off)
    else $error("pins enabled while master enable is off");

  property p_fpen_map;
    logic [1:0] n;
    logic [7:0] d;
    @(posedge i_clk) disable iff (!i_rst_b)
      (s_fpen_write, n = fpen_sel, d = wr_byte) ##1 o_waveform_run
      |-> o_fp_oe[{n, 3'h0} +: 8] == d;
  endproperty
  a_fpen_map: assert property (p_fpen_map)
    else $error("enable register byte landed on wrong frontplanes");

  property p_ram_store;
    logic [3:0] a;
    logic [7:0] d;
    @(posedge i_clk) disable iff (!i_rst_b)
      (s_ram_write, a = ram_sel, d = wr_byte)
      |=> o_segment_on_bit[{a, 3'h0} +: 8] == d;
  endproperty
  a_ram_store: assert property (p_ram_store)
    else $error("segment byte not stored on the next edge");

  property p_ram_keeps_master;
    @(posedge i_clk) disable iff (!i_rst_b)
      ram_wr |=> o_waveform_run == $past(o_waveform_run);
  endproperty
  a_ram_keeps_master: assert property (p_ram_keeps_master)
    else $error("segment write disturbed master enable");

  property p_reset_state;
    @(posedge i_clk) disable iff (!i_rst_b)
      !$past(i_rst_b) |-> (o_duty_select == DUTY_QUARTER)
      && (frontplane_output_enable == '0) && !o_waveform_run;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("wrong state at first edge after reset");

  property p_bp_duty;
    @(posedge i_clk) disable iff (!i_rst_b)
      o_waveform_run |-> o_bp_oe == bp_mask(o_duty_select);
  endproperty
  a_bp_duty: assert property (p_bp_duty)
    else $error("backplane enables do not match duty");

  property p_start;
    @(posedge i_clk) disable iff (!i_rst_b)
      $rose(o_waveform_run) |-> o_fp_oe == frontplane_output_enable;
  endproperty
  a_start: assert property (p_start)
    else $error("frontplanes did not start with master enable");

  property p_ctrl_write;
    logic [7:0] d;
    @(posedge i_clk) disable iff (!i_rst_b)
      (ctrl_wr, d = wr_byte) |=> (o_waveform_run == d[CTRL_EN_BIT])
      && (o_duty_select == d[CTRL_DUTY_LSB +: 2]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not applied on next edge");

  property p_bus_answer;
    @(posedge i_clk) disable iff (!i_rst_b)
      bus_req && o_avs_waitrequest |=> !o_avs_waitrequest ##1
      o_avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not given in one cycle");

  property p_fp_follow;
    logic [1:0] n;
    logic [7:0] d;
    @(posedge i_clk) disable iff (!i_rst_b)
      (s_fpen_write ##0 driver_master_enable, n = fpen_sel, d = wr_byte)
      |=> o_fp_oe[{n, 3'h0} +: 8] == d;
  endproperty
  a_fp_follow: assert property (p_fp_follow)
    else $error("enabled frontplane did not follow its enable bit");

  property p_fpen_idle;
    @(posedge i_clk) disable iff (!i_rst_b)
      fpen_wr && !driver_master_enable |=> o_fp_oe == '0;
  endproperty
  a_fpen_idle: assert property (p_fpen_idle)
    else $error("enable write reached pins while master is off");

  property p_ctrl_keeps_ram;
    @(posedge i_clk) disable iff (!i_rst_b)
      ctrl_wr |=> $stable(o_segment_on_bit);
  endproperty
  a_ctrl_keeps_ram: assert property (p_ctrl_keeps_ram)
    else $error("master enable write changed segment storage");

  property p_be_ignored;
    @(posedge i_clk) disable iff (!i_rst_b)
      i_avs_write && !o_avs_waitrequest && !i_avs_byteenable[0]
      |=> $stable(frontplane_output_enable) && $stable(o_fp_oe);
  endproperty
  a_be_ignored: assert property (p_be_ignored)
    else $error("write without low byte lane changed an enable");

  property p_ram_read;
    logic [3:0] a;
    @(posedge i_clk) disable iff (!i_rst_b)
      (s_ram_read, a = ram_sel)
      |=> o_avs_readdata == {24'h00_0000, segment_storage[a]};
  endproperty
  a_ram_read: assert property (p_ram_read)
    else $error("segment byte read back wrong");

  property p_wait_idle;
    @(posedge i_clk) disable iff (!i_rst_b)
      !bus_req |=> o_avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest low without a request");

  property p_unmapped_read;
    @(posedge i_clk) disable iff (!i_rst_b)
      i_avs_read && o_avs_waitrequest && !(is_ctrl || is_fpen || is_ram)
      |=> o_avs_readdata == '0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned data");

  property p_bias_write;
    logic d;
    @(posedge i_clk) disable iff (!i_rst_b)
      (ctrl_wr, d = wr_byte[CTRL_BIAS_BIT]) |=> o_bias_select == d;
  endproperty
  a_bias_write: assert property (p_bias_write)
    else $error("bias select not applied on next edge");

  property p_reset_pins;
    @(posedge i_clk) disable iff (!i_rst_b)
      !$past(i_rst_b) |-> !o_bias_select && (o_fp_oe == '0)
      && (o_bp_oe == 4'h0);
  endproperty
  a_reset_pins: assert property (p_reset_pins)
    else $error("pins or bias not at reset value after reset");

endmodule : seg_lcd_enable_ram

/* core/seg_lcd_pkg.sv */
// Purpose: Shared constants for the segment display enable and RAM block
// Assumes: 32-bit Avalon-MM slave, one register per aligned word
// Notes:   Register index times four gives the byte address
package seg_lcd_pkg;

  localparam int          ADDR_W        = 7;
  localparam int          DATA_W        = 32;
  localparam int          IDX_W         = 5;
  localparam int          NUM_FP        = 32;
  localparam int          NUM_BP        = 4;
  localparam int          FPEN_REGS     = 4;
  localparam int          RAM_BYTES     = 16;

  // Register indices
  localparam logic [4:0]  IDX_CTRL      = 5'h00;
  localparam logic [4:0]  IDX_FPEN_BASE = 5'h02;
  localparam logic [4:0]  IDX_FPEN_LAST = 5'h05;
  localparam logic [4:0]  IDX_RAM_BASE  = 5'h08;
  localparam logic [4:0]  IDX_RAM_LAST  = 5'h17;

  // Control register fields
  localparam int          CTRL_EN_BIT   = 7;
  localparam int          CTRL_BIAS_BIT = 2;
  localparam int          CTRL_DUTY_LSB = 0;

  // Duty select codes
  localparam logic [1:0]  DUTY_QUARTER  = 2'h0;
  localparam logic [1:0]  DUTY_STATIC   = 2'h1;
  localparam logic [1:0]  DUTY_HALF     = 2'h2;
  localparam logic [1:0]  DUTY_THIRD    = 2'h3;

  // Backplane enable masks per duty
  localparam logic [3:0]  BP_MASK_QUARTER = 4'hF;
  localparam logic [3:0]  BP_MASK_STATIC  = 4'h1;
  localparam logic [3:0]  BP_MASK_HALF    = 4'h3;
  localparam logic [3:0]  BP_MASK_THIRD   = 4'h7;

  // Reset values
  localparam logic [1:0]  DUTY_RESET    = 2'h0;
  localparam logic        BIAS_RESET    = 1'b0;
  localparam logic        EN_RESET      = 1'b0;
  localparam logic [31:0] FPEN_RESET    = 32'h0000_0000;

endpackage : seg_lcd_pkg

/* verif/lcd_glass_model.sv */
// Purpose: Behavioural segment glass on frontplane and backplane drivers
// Assumes: Segment lit only where both of its drivers are enabled
// Notes:   Lit map uses the same bit order as the segment storage
`timescale 1ns/1ps

module lcd_glass_model
  import seg_lcd_pkg::*;
(
  input  wire logic [NUM_FP-1:0]        i_fp_oe,
  input  wire logic [NUM_BP-1:0]        i_bp_oe,
  input  wire logic [NUM_FP*NUM_BP-1:0] i_segment_on_bit,
  output logic      [NUM_FP*NUM_BP-1:0] o_lit
);
  // Bit i joins frontplane i/4 with backplane i%4
  always_comb
    for (int i = 0; i < NUM_FP*NUM_BP; i++)
      o_lit[i] = i_segment_on_bit[i] & i_fp_oe[i/NUM_BP]
                 & i_bp_oe[i%NUM_BP];
endmodule : lcd_glass_model

/* verif/testbench.sv */
// Purpose: Self-checking bench for the segment enable and RAM block
// Assumes: One Avalon-MM request at a time, 25 MHz clock
// Notes:   Read data checked against a queue of expected values
`timescale 1ns/1ps

module testbench
  import seg_lcd_pkg::*;
;
  logic         i_clk = 1'b0;
  logic         i_rst_b = 1'b0;
  logic [6:0]   i_avs_address = 7'h00;
  logic         i_avs_read = 1'b0;
  logic         i_avs_write = 1'b0;
  logic [31:0]  i_avs_writedata = 32'h0;
  logic [3:0]   i_avs_byteenable = 4'h0;
  logic [31:0]  o_avs_readdata, o_fp_oe, fpen, rng;
  logic         o_avs_waitrequest, o_waveform_run, o_bias_select, bs;
  logic [1:0]   o_duty_select;
  logic [3:0]   o_bp_oe;
  logic [127:0] o_segment_on_bit, lit, seg, e;
  logic [31:0]  exp_q[$];
  int           fails = 0, n_checks = 0;

  always #20 i_clk = ~i_clk;

  seg_lcd_enable_ram u_seg_lcd_enable_ram (.i_clk, .i_rst_b,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
    .o_waveform_run, .o_duty_select, .o_bias_select, .o_fp_oe,
    .o_bp_oe, .o_segment_on_bit);
  lcd_glass_model u_lcd_glass_model (.i_fp_oe(o_fp_oe),
    .i_bp_oe(o_bp_oe), .i_segment_on_bit(o_segment_on_bit), .o_lit(lit));

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic bus(input logic rd, input logic [6:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    @(posedge i_clk);
    i_avs_read <= rd;
    i_avs_write <= !rd;
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, d};
    i_avs_byteenable <= be;
    do
    begin
      @(posedge i_clk);
    end
    while (o_avs_waitrequest !== 1'b0);
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    bus(1'b0, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'b1, a, 8'h00, 4'hF);
  endtask : rd

  task automatic outs(input logic run, input logic [1:0] dt);
    logic [3:0] m;
    m = (dt == 2'h0) ? 4'hF : (dt == 2'h1) ? 4'h1 : (dt == 2'h2) ? 4'h3 : 4'h7;
    #1;
    chk(128'({o_waveform_run, o_duty_select, o_bias_select, o_bp_oe, o_fp_oe}),
        128'({run, dt, bs, run ? m : 4'h0, run ? fpen : 32'h0}));
  endtask : outs

  // Read results leave the queue in issue order
  always @(posedge i_clk)
    if (i_rst_b && i_avs_read && o_avs_waitrequest === 1'b0)
      chk(128'(o_avs_readdata), 128'(exp_q.pop_front()));

  initial
  begin
    repeat (5000) @(posedge i_clk);
    fails++;
    end_of_test();
  end

  initial
  begin
    rng = 32'h0000_FDA6;
    fpen = 32'h0;
    bs = 1'b0;
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    outs(1'b0, 2'h0);
    rd(7'h00, 32'h0);
    fpen = xs();
    for (int n = 0; n < 4; n++)
      wr(7'h08 + 7'(4*n), fpen[8*n +: 8]);
    outs(1'b0, 2'h0);
    for (int n = 0; n < 4; n++)
      rd(7'h08 + 7'(4*n), 32'(fpen[8*n +: 8]));
    for (int k = 0; k < 16; k++)
    begin
      seg[8*k +: 8] = 8'(xs());
      wr(7'h20 + 7'(4*k), seg[8*k +: 8]);
    end
    #1 chk(o_segment_on_bit, seg);
    for (int d = 3; d >= 0; d--)
    begin
      wr(7'h00, {6'h20, 2'(d)});
      outs(1'b1, 2'(d));
    end
    for (int i = 0; i < 128; i++)
      e[i] = seg[i] & fpen[i/4];
    chk(lit, e);
    bus(1'b0, 7'h08, ~fpen[7:0], 4'h0);
    outs(1'b1, 2'h0);
    fpen[7:0] = ~fpen[7:0];
    wr(7'h08, fpen[7:0]);
    outs(1'b1, 2'h0);
    wr(7'h04, 8'hFF);
    rd(7'h04, 32'h0);
    wr(7'h00, 8'h00);
    outs(1'b0, 2'h0);
    for (int k = 0; k < 16; k++)
      rd(7'h20 + 7'(4*k), 32'(seg[8*k +: 8]));
    bs = 1'b1;
    wr(7'h00, 8'h84);
    outs(1'b1, 2'h0);
    rd(7'h00, 32'h0000_0084);
    rd(7'h20, 32'(seg[7:0]));
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    fpen = 32'h0;
    bs = 1'b0;
    outs(1'b0, 2'h0);
    rd(7'h0C, 32'h0);
    rd(7'h00, 32'h0);
    repeat (2) @(posedge i_clk);
    end_of_test();
  end
endmodule : testbench
